/* hdl/csba_core.sv */
// executor for compare-skip-less/greater and decimal adjust of the working register
//
// Implementation choices: the register offsets and the strobed register port.
`timescale 1ns/1ps

// What this block does
// - opcode 0110 000a with 8-bit file address is the less-than compare.
// - less-than: unsigned file minus working register; smaller discards fetch, no flags.
// - greater-than: file above working register skips next instruction, else continues.
// - access bit 0 picks access bank, 1 uses bank select register.
// - access bit 0, extended set on, address up to 95: indexed literal offset.
// - one cycle without skip; skip adds one, two or three cycles by word count.
// - decode Q1, read file Q2, process Q3, idle Q4; skip cycles all idle.
// - decimal adjust turns 8-bit packed BCD sum into valid packed BCD.
// - upper nibble plus carry over 9, or carry set: add 6 plus carry.
// - opcode 0x0007, one cycle, no operands, only carry flag changes.
// - decimal adjust: decode Q1, read W Q2, process Q3, write W Q4.
module csba_core #(
    parameter int BANK_W       = 6,
    parameter int ACCESS_HI_BK = 63,
    parameter int ADDR_W       = BANK_W + csba_pkg::FADDR_W
) (
    input  wire logic                     clk,
    input  wire logic                     srst,
    input  wire logic                     instr_valid,
    input  wire logic [csba_pkg::OPC_W-1:0] instr_word,
    input  wire logic [1:0]               next_words,
    input  wire logic [7:0]               working_register,
    input  wire logic                     carry_flag,
    input  wire logic                     digit_carry_flag,
    input  wire logic [BANK_W-1:0]        bank_select_register,
    input  wire logic                     ext_set_enable,
    input  wire logic [ADDR_W-1:0]        index_base,
    input  wire logic [7:0]               file_rdata,
    output logic [1:0]                    q_phase,
    output logic                          instr_taken,
    output logic                          file_read,
    output logic [ADDR_W-1:0]             file_addr,
    output logic                          indexed_mode,
    output logic                          discard_fetched,
    output logic                          nop_cycle,
    output logic                          working_register_write,
    output logic [7:0]                    working_register_wdata,
    output logic                          carry_write,
    output logic                          carry_next,
    output logic                          busy
);
    import csba_pkg::*;

    localparam logic [BANK_W-1:0] ACCESS_HI = BANK_W'(ACCESS_HI_BK);

    csba_phase_type   phase;
    csba_state_type   state;
    csba_decoded_type cur;
    logic [1:0]       skip_left;
    logic             skip_pending;
    logic [1:0]       skip_len;

    function automatic csba_decoded_type decode_word(input logic [OPC_W-1:0] w);
        csba_decoded_type d;
        d.op         = OP_NONE;
        d.access_sel = w[ACCESS_BIT];
        d.faddr      = w[FADDR_W-1:0];
        if (w[OPC_HI_MSB:OPC_HI_LSB] == OPC_CMP_LT) begin
            d.op = OP_CMP_LT;
        end else if (w[OPC_HI_MSB:OPC_HI_LSB] == OPC_CMP_GT) begin
            d.op = OP_CMP_GT;
        end else if (w == OPC_DECADJ) begin
            d.op = OP_DECADJ;
        end
        return d;
    endfunction : decode_word

    function automatic logic is_indexed(input logic a, input logic en, input logic [7:0] f);
        return !a && en && (f <= INDEXED_LIMIT);
    endfunction : is_indexed

    function automatic logic [ADDR_W-1:0] file_address(
        input logic              a,
        input logic              en,
        input logic [7:0]        f,
        input logic [BANK_W-1:0] bank,
        input logic [ADDR_W-1:0] base
    );
        logic [ADDR_W-1:0] r;
        r = '0;
        if (is_indexed(a, en, f)) begin
            r = ADDR_W'(base + ADDR_W'(f));
        end else if (a) begin
            r = {bank, f};
        end else if (f <= INDEXED_LIMIT) begin
            r = {{BANK_W{1'b0}}, f};
        end else begin
            r = {ACCESS_HI, f};
        end
        return r;
    endfunction : file_address

    // decode of the word on the bus, shared by the latch, the read request and busy
    csba_decoded_type in_dec;
    logic             in_is_cmp;
    logic             in_known;

    always_comb begin
        in_dec    = decode_word(instr_word);
        in_is_cmp = (in_dec.op == OP_CMP_LT) || (in_dec.op == OP_CMP_GT);
        in_known  = (in_dec.op != OP_NONE);
    end

    // decimal adjust datapath, nibble corrections
    logic [4:0] lo_sum;
    logic [3:0] lo_new;
    logic       lo_cy;
    logic [4:0] hi_in;
    logic [4:0] hi_sum;
    logic       hi_adj;
    logic [7:0] next_working_register;
    logic       next_carry;

    always_comb begin
        lo_sum = {1'b0, working_register[3:0]};
        if ((working_register[3:0] > BCD_MAX_DIGIT) || digit_carry_flag) begin
            lo_sum = 5'({1'b0, working_register[3:0]} + BCD_CORRECT);
        end
        lo_new = lo_sum[3:0];
        lo_cy  = lo_sum[4];
        // the low-nibble correction carry feeds the upper digit
        hi_in  = 5'({1'b0, working_register[7:4]} + {4'h0, lo_cy});
        hi_adj = (hi_in > {1'b0, BCD_MAX_DIGIT}) || carry_flag;
        hi_sum = hi_in;
        if (hi_adj) begin
            hi_sum = 5'(hi_in + BCD_CORRECT);
        end
        next_working_register  = {hi_sum[3:0], lo_new};
        next_carry = carry_flag | hi_sum[4];
    end

    // unsigned compare result used in Q3
    logic cmp_less;
    logic cmp_greater;
    logic next_skip;

    always_comb begin
        cmp_less    = file_rdata < working_register;
        cmp_greater = file_rdata > working_register;
        next_skip   = 1'b0;
        unique case (cur.op)
            OP_CMP_LT: next_skip = cmp_less;
            OP_CMP_GT: next_skip = cmp_greater;
            OP_DECADJ: next_skip = 1'b0;
            OP_NONE:   next_skip = 1'b0;
        endcase
    end

    // clamp unexpected word counts into the supported 1..3 range
    always_comb begin
        skip_len = next_words;
        if (next_words < WORDS_MIN) begin
            skip_len = WORDS_MIN;
        end
    end

    // quadrature phase counter, free running
    always_ff @(posedge clk) begin
        if (srst) begin
            phase <= Q1;
        end else begin
            unique case (phase)
                Q1: phase <= Q2;
                Q2: phase <= Q3;
                Q3: phase <= Q4;
                Q4: phase <= Q1;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            q_phase <= 2'h0;
        end else begin
            q_phase <= 2'(phase + 2'h1);
        end
    end

    // instruction latch, taken in Q1 of an execution cycle
    always_ff @(posedge clk) begin
        if (srst) begin
            cur         <= '{op: OP_NONE, access_sel: 1'b0, faddr: 8'h00};
            instr_taken <= 1'b0;
        end else begin
            instr_taken <= 1'b0;
            if (phase == Q1) begin
                cur <= '{op: OP_NONE, access_sel: 1'b0, faddr: 8'h00};
                if (state == ST_EXEC && instr_valid) begin
                    cur         <= in_dec;
                    instr_taken <= 1'b1;
                end
            end
        end
    end

    // file read request, high through Q2 of a compare
    always_ff @(posedge clk) begin
        if (srst) begin
            file_read    <= 1'b0;
            file_addr    <= '0;
            indexed_mode <= 1'b0;
        end else begin
            file_read <= 1'b0;
            if (phase == Q1 && state == ST_EXEC && instr_valid) begin
                if (in_is_cmp) begin
                    file_read    <= 1'b1;
                    file_addr    <= file_address(instr_word[ACCESS_BIT], ext_set_enable,
                                                 instr_word[FADDR_W-1:0],
                                                 bank_select_register, index_base);
                    indexed_mode <= is_indexed(instr_word[ACCESS_BIT], ext_set_enable,
                                               instr_word[FADDR_W-1:0]);
                end
            end
        end
    end

    // working register write in Q4, only carry flag touched
    always_ff @(posedge clk) begin
        if (srst) begin
            working_register_write  <= 1'b0;
            working_register_wdata  <= WORKING_REGISTER_RESET;
            carry_write <= 1'b0;
            carry_next  <= 1'b0;
        end else begin
            working_register_write  <= 1'b0;
            carry_write <= 1'b0;
            if (phase == Q3 && cur.op == OP_DECADJ) begin
                working_register_write  <= 1'b1;
                working_register_wdata  <= next_working_register;
                carry_write <= 1'b1;
                carry_next  <= next_carry;
            end
        end
    end

    // compare outcome: discard pulse in Q4, compare never writes status
    always_ff @(posedge clk) begin
        if (srst) begin
            discard_fetched <= 1'b0;
            skip_pending    <= 1'b0;
        end else begin
            discard_fetched <= 1'b0;
            if (phase == Q3) begin
                discard_fetched <= next_skip;
                skip_pending    <= next_skip;
            end else if (phase == Q4) begin
                skip_pending <= 1'b0;
            end
        end
    end

    // skip sequencer: one idle cycle per word of the discarded instruction
    always_ff @(posedge clk) begin
        if (srst) begin
            state     <= ST_EXEC;
            skip_left <= 2'h0;
        end else if (phase == Q4) begin
            unique case (state)
                ST_EXEC: begin
                    if (skip_pending) begin
                        state     <= ST_SKIP;
                        skip_left <= skip_len;
                    end
                end
                ST_SKIP: begin
                    if (skip_left <= WORDS_MIN) begin
                        state     <= ST_EXEC;
                        skip_left <= 2'h0;
                    end else begin
                        skip_left <= 2'(skip_left - 2'h1);
                    end
                end
            endcase
        end
    end

    // nop_cycle and busy track the next cycle's state, so they line up with it
    always_ff @(posedge clk) begin
        if (srst) begin
            nop_cycle <= 1'b0;
        end else if (phase == Q4) begin
            nop_cycle <= (state == ST_EXEC) ? skip_pending
                                            : (skip_left > WORDS_MIN);
        end
    end

    // unknown words are accepted but leave busy low
    always_ff @(posedge clk) begin
        if (srst) begin
            busy <= 1'b0;
        end else if (phase == Q4) begin
            busy <= (state == ST_EXEC) ? skip_pending : (skip_left > WORDS_MIN);
        end else if (phase == Q1 && state == ST_EXEC && instr_valid) begin
            busy <= in_known;
        end
    end

endmodule : csba_core

/* shared/csba_pkg.sv */
// shared constants and types for the compare-skip and decimal adjust executor
package csba_pkg;

    // opcode layout
    localparam int          OPC_W         = 16;
    localparam int          FADDR_W       = 8;
    localparam logic [6:0]  OPC_CMP_LT    = 7'h30;   // 0110 000
    localparam logic [6:0]  OPC_CMP_GT    = 7'h32;   // 0110 010
    localparam int          OPC_HI_MSB    = 15;
    localparam int          OPC_HI_LSB    = 9;
    localparam int          ACCESS_BIT    = 8;
    localparam logic [15:0] OPC_DECADJ    = 16'h0007;

    // addressing
    localparam logic [7:0]  INDEXED_LIMIT = 8'h5F;

    // decimal adjust
    localparam logic [3:0]  BCD_MAX_DIGIT = 4'h9;
    localparam logic [4:0]  BCD_CORRECT   = 5'h06;

    // skip lengths
    localparam logic [1:0]  WORDS_MIN     = 2'h1;
    localparam logic [1:0]  WORDS_MAX     = 2'h3;

    // reset values
    localparam logic [7:0]  WORKING_REGISTER_RESET    = 8'h00;

    typedef enum logic [1:0] {
        Q1,
        Q2,
        Q3,
        Q4
    } csba_phase_type;

    typedef enum logic [1:0] {
        OP_NONE,
        OP_CMP_LT,
        OP_CMP_GT,
        OP_DECADJ
    } csba_op_type;

    typedef enum logic {
        ST_EXEC,
        ST_SKIP
    } csba_state_type;

    typedef struct packed {
        csba_op_type op;
        logic        access_sel;
        logic [7:0]  faddr;
    } csba_decoded_type;

endpackage : csba_pkg

/* testbench/csba_checker.sv */
// concurrent checks on the ports of the compare-skip and decimal adjust executor
`timescale 1ns/1ps
module csba_checker #(
    parameter int BANK_W       = 6,
    parameter int ACCESS_HI_BK = 63,
    parameter int ADDR_W       = 14
) (
    input wire logic                         clk,
    input wire logic                         srst,
    input wire logic                         instr_valid,
    input wire logic [csba_pkg::OPC_W-1:0]   instr_word,
    input wire logic [1:0]                   q_phase,
    input wire logic                         instr_taken,
    input wire logic                         file_read,
    input wire logic                         discard_fetched,
    input wire logic                         nop_cycle,
    input wire logic                         working_register_write,
    input wire logic                         carry_write,
    input wire logic                         busy
);
    import csba_pkg::*;
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    logic       take;
    logic [3:0] nop_run;
    assign take = (q_phase == 2'h0) && instr_valid && !nop_cycle;
    // run length of skip cycles, at most three instruction cycles
    always_ff @(posedge clk) begin
        if (srst || !nop_cycle) nop_run <= 4'h0;
        else                    nop_run <= nop_run + 4'h1;
    end
    chk_adj_timing: assert property (take && instr_word == OPC_DECADJ |=>
        instr_taken && busy ##2 working_register_write && carry_write) else $error("adjust timing wrong");
    chk_lt_read: assert property (take && instr_word[15:9] == OPC_CMP_LT |=> file_read)
        else $error("less compare not read");
    chk_gt_read: assert property (take && instr_word[15:9] == OPC_CMP_GT |=> file_read)
        else $error("greater compare not read");
    chk_cmp_noflag: assert property (file_read |-> ##2 !carry_write && !working_register_write)
        else $error("compare wrote status or W");
    chk_discard_nop: assert property (
        discard_fetched |-> q_phase == 2'h3 ##1 nop_cycle[*4])
        else $error("skip cycle malformed");
    chk_nop_idle: assert property (
        nop_cycle |-> busy && !file_read && !working_register_write && !instr_taken)
        else $error("activity during skip cycle");
    chk_nop_end: assert property ($fell(nop_cycle) |-> q_phase == 2'h0)
        else $error("skip ended off cycle boundary");
    chk_skip_max: assert property (nop_run <= 4'hC)
        else $error("skip longer than three cycles");
    chk_taken_q2: assert property (instr_taken |-> q_phase == 2'h1)
        else $error("take pulse outside Q2");
endmodule : csba_checker

/* testbench/test_compare_skip_and_bcd_adjust.sv */
// self-checking bench for the compare-skip and decimal adjust executor
`timescale 1ns/1ps
module test_compare_skip_and_bcd_adjust;
    import csba_pkg::*;
    logic clk = 1'b0, srst = 1'b1, instr_valid = 1'b0, carry_flag = 1'b0;
    logic digit_carry_flag = 1'b0, ext_set_enable = 1'b0;
    logic [15:0] instr_word = 16'h0000;
    logic [1:0]  next_words = 2'h1;
    logic [7:0]  working_register = 8'h00, file_rdata = 8'h00;
    logic [5:0]  bank_select_register = 6'h00;
    logic [13:0] index_base = 14'h0000, file_addr;
    logic [1:0]  q_phase;
    logic instr_taken, file_read, indexed_mode, discard_fetched, nop_cycle;
    logic working_register_write, carry_write, carry_next, busy;
    logic [7:0]  working_register_wdata;
    logic [15:0] wd;
    int          n_errors = 0, check_count = 0, k;
    always #10 clk = ~clk;
    csba_core csba_core_inst (.clk, .srst, .instr_valid, .instr_word, .next_words,
        .working_register, .carry_flag, .digit_carry_flag, .bank_select_register,
        .ext_set_enable, .index_base, .file_rdata, .q_phase, .instr_taken, .file_read,
        .file_addr, .indexed_mode, .discard_fetched, .nop_cycle, .working_register_write, .working_register_wdata,
        .carry_write, .carry_next, .busy);
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    // upper digit takes the carry of the low correction, as the examples require
    function automatic logic [8:0] exp_adj(logic [7:0] w, logic c, logic dc);
        logic [4:0] lo, hi;
        lo = {1'b0, w[3:0]};
        if (lo > 5'h09 || dc) lo = lo + 5'h06;
        hi = {1'b0, w[7:4]} + {4'h0, lo[4]};
        if (hi > 5'h09 || c) hi = hi + 5'h06;
        return {c | hi[4], hi[3:0], lo[3:0]};
    endfunction : exp_adj
    localparam int ACCESS_HI_BK_TB = 63;
    function automatic logic [13:0] exp_addr(logic a, logic ext, logic [7:0] f,
                                             logic [5:0] bk, logic [13:0] base);
        if (a) return {bk, f};
        if (ext && f <= INDEXED_LIMIT) return base + {6'h00, f};
        if (f > INDEXED_LIMIT) return {6'(ACCESS_HI_BK_TB), f};
        return {6'h00, f};
    endfunction : exp_addr
    // entered just after an edge in a Q4 cycle; returns in the last Q4 of the instruction
    task automatic exec(input logic [15:0] wdi, input logic [7:0] w, input logic [7:0] fr,
                        input logic c, input logic dc, input logic ext, input logic [1:0] nw);
        logic [5:0]  bk;
        logic [13:0] base;
        logic        is_cmp, skip;
        logic [8:0]  adj;
        int          n;
        bk = 6'($urandom);
        base = 14'($urandom);
        is_cmp = (wdi[15:9] == OPC_CMP_LT) || (wdi[15:9] == OPC_CMP_GT);
        skip = (wdi[15:9] == OPC_CMP_LT && fr < w) || (wdi[15:9] == OPC_CMP_GT && fr > w);
        adj = exp_adj(w, c, dc);
        n = (nw == 2'h0) ? 1 : int'(nw);
        @(posedge clk);
        instr_valid <= 1'b1;
        instr_word <= wdi;
        working_register <= w;
        file_rdata <= fr;
        carry_flag <= c;
        digit_carry_flag <= dc;
        ext_set_enable <= ext;
        next_words <= nw;
        bank_select_register <= bk;
        index_base <= base;
        @(posedge clk);
        instr_valid <= 1'b0;
        #1;
        check("busy", 16'(busy), 16'(is_cmp || wdi == OPC_DECADJ));
        check("q_phase", 16'(q_phase), 16'h0001);
        check("file_read", 16'(file_read), 16'(is_cmp));
        check("instr_taken", 16'(instr_taken), 16'h0001);
        if (is_cmp) begin
            check("file_addr", 16'(file_addr),
                  16'(exp_addr(wdi[8], ext, wdi[7:0], bk, base)));
            check("indexed", 16'(indexed_mode),
                  16'(!wdi[8] && ext && wdi[7:0] <= INDEXED_LIMIT));
        end
        repeat (2) @(posedge clk);
        #1;
        check("discard", 16'(discard_fetched), 16'(skip));
        check("working_register_write", 16'(working_register_write), 16'(wdi == OPC_DECADJ));
        check("carry_write", 16'(carry_write), 16'(wdi == OPC_DECADJ));
        if (wdi == OPC_DECADJ) begin
            check("working_register_wdata", 16'(working_register_wdata), 16'(adj[7:0]));
            check("carry_next", 16'(carry_next), 16'(adj[8]));
        end
        // a word offered during skip cycles must be ignored
        for (int i = 0; skip && i < 4 * n; i++) begin
            @(posedge clk);
            instr_valid <= (i < 4 * n - 1);
            instr_word <= OPC_DECADJ;
            #1;
            check("nop_cycle", 16'(nop_cycle), 16'h0001);
            check("taken", 16'(instr_taken), 16'h0000);
        end
    endtask : exec
    task automatic finish_test();
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : finish_test
    initial begin
        void'($urandom(42));
        repeat (4) @(posedge clk);
        #1;
        check("reset wdata", 16'(working_register_wdata), 16'h0000);
        check("reset busy", 16'(busy), 16'h0000);
        @(posedge clk);
        srst <= 1'b0;
        for (int i = 0; i < 8 && q_phase !== 2'h3; i++) begin
            @(posedge clk);
            #1;
        end
        if (q_phase !== 2'h3) n_errors++;
        else begin
            exec(OPC_DECADJ, 8'hA5, 8'h00, 1'b0, 1'b0, 1'b0, 2'h1);
            exec(OPC_DECADJ, 8'hCE, 8'h00, 1'b0, 1'b0, 1'b0, 2'h1);
            exec(16'h605F, 8'h10, 8'h0F, 1'b0, 1'b0, 1'b1, 2'h3);
            exec(16'h6060, 8'h20, 8'h20, 1'b0, 1'b0, 1'b1, 2'h1);
            exec(16'h6580, 8'h80, 8'h81, 1'b0, 1'b0, 1'b0, 2'h2);
            exec(16'h6480, 8'h80, 8'h80, 1'b0, 1'b0, 1'b0, 2'h0);
            for (int i = 0; i < 300; i++) begin
                k = $urandom % 4;
                wd = (k == 0) ? {OPC_CMP_LT, 9'($urandom)} : (k == 1) ? {OPC_CMP_GT, 9'($urandom)}
                   : (k == 2) ? OPC_DECADJ : {4'hF, 12'($urandom)};
                exec(wd, 8'($urandom), 8'($urandom), 1'($urandom), 1'($urandom), 1'($urandom),
                     2'($urandom));
            end
        end
        finish_test();
    end
endmodule : test_compare_skip_and_bcd_adjust
bind csba_core csba_checker #(.BANK_W(BANK_W), .ACCESS_HI_BK(ACCESS_HI_BK), .ADDR_W(ADDR_W))
    csba_checker_inst (.clk, .srst, .instr_valid, .instr_word, .q_phase, .instr_taken,
        .file_read, .discard_fetched, .nop_cycle, .working_register_write, .carry_write, .busy);
